// ===== pdc_consts.vh
`ifndef PDC_CONSTS_VH
`define PDC_CONSTS_VH

// register select codes
`define PDC_RS_WRITE_INDEX 2'h0
`define PDC_RS_LUT_DATA 2'h1
`define PDC_RS_INDEXED 2'h2
`define PDC_RS_READ_INDEX 2'h3

// indexes behind the indexed select code
`define PDC_IDX_PIXEL_FORMAT 8'h01
`define PDC_IDX_OUTPUT_CTRL 8'h05
`define PDC_IDX_CLOCK_SELECT 8'h06

// reset values
`define PDC_PIXEL_FORMAT_RESET 8'h00
`define PDC_OUTPUT_CTRL_RESET 8'h00
`define PDC_CLOCK_SELECT_RESET 8'h00

// writable bit masks, reserved bits excluded
`define PDC_PIXEL_FORMAT_MASK 8'hFB
`define PDC_OUTPUT_CTRL_MASK 8'h1E
`define PDC_CLOCK_SELECT_MASK 8'hBB

// pixel format fields
`define PDC_PF_MODE_HI 7
`define PDC_PF_MODE_LO 4
`define PDC_PF_POWER_DOWN 3
`define PDC_PF_EIGHT_BIT 1
`define PDC_PF_EXT_ACCESS 0

// output control fields
`define PDC_OC_PEDESTAL 4
`define PDC_OC_CLK1_OFF 3
`define PDC_OC_CLK2_OFF 2
`define PDC_OC_SENSE_DIS 1

// clock select fields
`define PDC_CS_CLK1_REG 7
`define PDC_CS_CLK1_HI 5
`define PDC_CS_CLK1_LO 4
`define PDC_CS_CLK2_REG 3
`define PDC_CS_CLK2_HI 1
`define PDC_CS_CLK2_LO 0

// color mode codes
`define PDC_MODE_PSEUDO8 4'h0
`define PDC_MODE_RGB15 4'h1
`define PDC_MODE_PSEUDO8X2 4'h2
`define PDC_MODE_RGB565 4'h3
`define PDC_MODE_PSEUDO8_2CLK 4'h4
`define PDC_MODE_RGB24_16_2CLK 4'h5
`define PDC_MODE_RGB565_8_2CLK 4'h6
`define PDC_MODE_RGB24_8_3CLK 4'h7
`define PDC_MODE_RGB24X2_16_3CLK 4'hE

// frequency select codes, in kHz
`define PDC_F1_CODE0_KHZ 17'h061E1
`define PDC_F1_CODE1_KHZ 17'h06E1D
`define PDC_F1_SETC_RESET_KHZ 17'h0C3C2
`define PDC_F1_SETD_RESET_KHZ 17'h125A2
`define PDC_F2_CODE0_KHZ 17'h0751B
`define PDC_F2_CODE1_KHZ 17'h09C9B
`define PDC_F2_CODE2_KHZ 17'h0C3C2
`define PDC_F2_SETD_RESET_KHZ 17'h0EA35

// clocks per pixel group
`define PDC_CLKS_ONE 2'h1
`define PDC_CLKS_TWO 2'h2
`define PDC_CLKS_THREE 2'h3

`endif

// ===== pdc_mode_decode.v
`include "pdc_consts.vh"
`default_nettype none

// decodes the color mode field into pixel width and clocks per pixel group
module pdc_mode_decode (
    // mode
    input wire [3:0] mode_i,
    // decoded
    output reg [4:0] bits_per_pixel_o,
    output reg [1:0] clocks_per_group_o,
    output reg mode_valid_o
);
    always @* begin
        bits_per_pixel_o = 5'h08;
        clocks_per_group_o = `PDC_CLKS_ONE;
        mode_valid_o = 1'b1;
        case (mode_i)
            `PDC_MODE_PSEUDO8: begin
                bits_per_pixel_o = 5'h08;
            end
            `PDC_MODE_RGB15: begin
                bits_per_pixel_o = 5'h0F;
            end
            `PDC_MODE_PSEUDO8X2: begin
                bits_per_pixel_o = 5'h08;
            end
            `PDC_MODE_RGB565: begin
                bits_per_pixel_o = 5'h10;
            end
            `PDC_MODE_PSEUDO8_2CLK: begin
                bits_per_pixel_o = 5'h08;
                clocks_per_group_o = `PDC_CLKS_TWO;
            end
            `PDC_MODE_RGB24_16_2CLK: begin
                bits_per_pixel_o = 5'h18;
                clocks_per_group_o = `PDC_CLKS_TWO;
            end
            `PDC_MODE_RGB565_8_2CLK: begin
                bits_per_pixel_o = 5'h10;
                clocks_per_group_o = `PDC_CLKS_TWO;
            end
            `PDC_MODE_RGB24_8_3CLK: begin
                bits_per_pixel_o = 5'h18;
                clocks_per_group_o = `PDC_CLKS_THREE;
            end
            `PDC_MODE_RGB24X2_16_3CLK: begin
                bits_per_pixel_o = 5'h18;
                clocks_per_group_o = `PDC_CLKS_THREE;
            end
            default: begin
                // reserved codes fall back to plain pseudocolor
                mode_valid_o = 1'b0;
            end
        endcase
    end
endmodule

`default_nettype wire

// ===== pdc_freq_select.v
`include "pdc_consts.vh"
`default_nettype none

// picks the frequency code and nominal frequency for one synthesized clock
module pdc_freq_select #(
    parameter FIRST = 1
) (
    // sources
    input wire use_reg_i,
    input wire [1:0] reg_code_i,
    input wire [1:0] pin_code_i,
    // result
    output wire [1:0] code_o,
    output reg [16:0] freq_khz_o
);
    assign code_o = use_reg_i ? reg_code_i : pin_code_i;

    always @* begin
        freq_khz_o = 17'h00000;
        case (code_o)
            2'h0: begin
                freq_khz_o = FIRST ? `PDC_F1_CODE0_KHZ : `PDC_F2_CODE0_KHZ;
            end
            2'h1: begin
                freq_khz_o = FIRST ? `PDC_F1_CODE1_KHZ : `PDC_F2_CODE1_KHZ;
            end
            2'h2: begin
                // set C of the first clock holds its reset value here
                freq_khz_o = FIRST ? `PDC_F1_SETC_RESET_KHZ : `PDC_F2_CODE2_KHZ;
            end
            default: begin
                freq_khz_o = FIRST ? `PDC_F1_SETD_RESET_KHZ : `PDC_F2_SETD_RESET_KHZ;
            end
        endcase
    end
endmodule

`default_nettype wire

// ===== pdc_regs.v
`include "pdc_consts.vh"
`default_nettype none

// Function
// - an 8-bit palette write index, reached with select code 00 and untouched by reset, names the next entry written.
// - an 8-bit palette read index, reached with select code 11 and untouched by reset, names the next entry read.
// - the pixel format register sits at index 1 behind select code 10 and resets to zero.
// - pixel format bits 7:4 pick 8-bit pseudocolor, 15-bit, doubled 8-bit or 5-6-5 for codes 0 to 3.
// - codes 4 to 7 assemble 8-bit, 24-bit on 16, 5-6-5 on 8 and 24-bit on 8 pixels over two or three clocks.
// - code 14 packs two 24-bit pixels on 16 inputs over three clocks and the other high codes are reserved.
// - pixel format bit 0 enables extended access, bit 3 powers down, bit 1 selects 8-bit data, bit 2 is reserved.
// - the output control register sits at index 5 behind select code 10, resets to zero, bits 7:5 and 0 reserved.
// - output control bit 4 turns the blank pedestal on.
// - output control bit 3 powers down the first synthesized clock.
// - output control bit 2 powers down the second synthesized clock and bit 1 disables the sense output.
// - the clock select register sits at index 6 behind select code 10, resets to zero, bits 6 and 2 reserved.
// - the first clock takes its frequency from the pins when bit 7 is 0, else from bits 5:4.
// - the second clock takes its frequency from the pins when bit 3 is 0, else from bits 1:0.
module pdc_regs (
    // clock and reset
    input wire ref_clk_i,
    input wire reset_n_i,
    // host register port
    input wire [1:0] register_select_lines_i,
    input wire write_strobe_i,
    input wire read_strobe_i,
    input wire [7:0] write_data_i,
    output reg [7:0] read_data_o,
    // frequency select pins
    input wire [1:0] frequency_select_pins_i,
    // pixel format controls
    output reg [3:0] color_mode_o,
    output reg color_mode_valid_o,
    output reg [4:0] bits_per_pixel_o,
    output reg [1:0] clocks_per_group_o,
    output reg device_power_down_o,
    output reg eight_bit_data_o,
    output reg extended_access_o,
    // output controls
    output reg blank_pedestal_en_o,
    output reg synth_clock_first_off_o,
    output reg synth_clock_second_off_o,
    output reg sense_disable_o,
    // synthesized clock selection
    output reg [1:0] first_clock_code_o,
    output reg [16:0] first_clock_khz_o,
    output reg [1:0] second_clock_code_o,
    output reg [16:0] second_clock_khz_o,
    // palette indexes
    output reg [7:0] palette_write_index_o,
    output reg [7:0] palette_read_index_o
);
    // palette indexes are deliberately left out of reset
    reg [7:0] palette_write_index;
    reg [7:0] palette_read_index;
    reg [7:0] pixel_format_control;
    reg [7:0] output_control;
    reg [7:0] clock_select_control;
    reg [7:0] next_read_data;
    // indexed readback is muxed first, then joined with the index registers
    reg [7:0] next_indexed_data;

    wire [4:0] dec_bits;
    wire [1:0] dec_clocks;
    wire dec_valid;
    wire [1:0] first_code;
    wire [16:0] first_khz;
    wire [1:0] second_code;
    wire [16:0] second_khz;

    // select code decode
    wire write_index_sel;
    wire read_index_sel;
    wire indexed_sel;

    // indexed register hits follow the write index as it stands at the edge
    wire pixel_format_hit;
    wire output_ctrl_hit;
    wire clock_select_hit;

    // write enables; select 01 has none, so writes there vanish
    wire write_index_we;
    wire read_index_we;
    wire pixel_format_we;
    wire output_ctrl_we;
    wire clock_select_we;

    // named views of the control fields feeding the output flops
    wire [3:0] color_mode_field;
    wire power_down_field;
    wire eight_bit_field;
    wire ext_access_field;
    wire pedestal_field;
    wire first_off_field;
    wire second_off_field;
    wire sense_dis_field;

    function is_index;
        input [7:0] index;
        input [7:0] target;
        begin
            is_index = (index == target);
        end
    endfunction

    // keeps reserved bits at zero on every write
    function [7:0] masked;
        input [7:0] data;
        input [7:0] mask;
        begin
            masked = data & mask;
        end
    endfunction

    // compares a select code against one of its four values
    function is_select;
        input [1:0] select;
        input [1:0] target;
        begin
            is_select = (select == target);
        end
    endfunction

    // three select codes are decoded once for the write enables; the read mux cases on the select lines itself
    assign write_index_sel = is_select(register_select_lines_i, `PDC_RS_WRITE_INDEX);
    assign read_index_sel = is_select(register_select_lines_i, `PDC_RS_READ_INDEX);
    assign indexed_sel = is_select(register_select_lines_i, `PDC_RS_INDEXED);

    assign pixel_format_hit = is_index(palette_write_index, `PDC_IDX_PIXEL_FORMAT);
    assign output_ctrl_hit = is_index(palette_write_index, `PDC_IDX_OUTPUT_CTRL);
    assign clock_select_hit = is_index(palette_write_index, `PDC_IDX_CLOCK_SELECT);

    assign write_index_we = write_strobe_i && write_index_sel;
    assign read_index_we = write_strobe_i && read_index_sel;
    // reset outranks these in the register processes below
    assign pixel_format_we = write_strobe_i && indexed_sel && pixel_format_hit;
    assign output_ctrl_we = write_strobe_i && indexed_sel && output_ctrl_hit;
    assign clock_select_we = write_strobe_i && indexed_sel && clock_select_hit;

    // field views; the bit positions live in the constants header
    assign color_mode_field = pixel_format_control[`PDC_PF_MODE_HI:`PDC_PF_MODE_LO];
    assign power_down_field = pixel_format_control[`PDC_PF_POWER_DOWN];
    assign eight_bit_field = pixel_format_control[`PDC_PF_EIGHT_BIT];
    assign ext_access_field = pixel_format_control[`PDC_PF_EXT_ACCESS];
    assign pedestal_field = output_control[`PDC_OC_PEDESTAL];
    assign first_off_field = output_control[`PDC_OC_CLK1_OFF];
    assign second_off_field = output_control[`PDC_OC_CLK2_OFF];
    assign sense_dis_field = output_control[`PDC_OC_SENSE_DIS];

    // palette write index: no reset by design
    // until the host writes it the index is unknown, so indexed access must follow an index write
    always @(posedge ref_clk_i) begin
        if (write_index_we) begin
            palette_write_index <= write_data_i;
        end
    end

    // palette read index: no reset by design
    always @(posedge ref_clk_i) begin
        if (read_index_we) begin
            palette_read_index <= write_data_i;
        end
    end

    // pixel format control; reserved bit 2 is never stored
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            pixel_format_control <= `PDC_PIXEL_FORMAT_RESET;
        end else if (pixel_format_we) begin
            pixel_format_control <= masked(write_data_i, `PDC_PIXEL_FORMAT_MASK);
        end
    end

    // output control; reserved bits 7:5 and 0 are never stored
    // the power-down and sense bits only report here, the pins they act on sit outside
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            output_control <= `PDC_OUTPUT_CTRL_RESET;
        end else if (output_ctrl_we) begin
            output_control <= masked(write_data_i, `PDC_OUTPUT_CTRL_MASK);
        end
    end

    // clock select control; reserved bits 6 and 2 are never stored
    // frequency selection follows this register one flop stage later
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            clock_select_control <= `PDC_CLOCK_SELECT_RESET;
        end else if (clock_select_we) begin
            clock_select_control <= masked(write_data_i, `PDC_CLOCK_SELECT_MASK);
        end
    end

    // indexed read mux; unmapped indexes read as zero
    always @* begin
        next_indexed_data = 8'h00;
        if (pixel_format_hit) begin
            next_indexed_data = pixel_format_control;
        end else if (output_ctrl_hit) begin
            next_indexed_data = output_control;
        end else if (clock_select_hit) begin
            next_indexed_data = clock_select_control;
        end
    end

    // select read mux; the unused select reads as zero
    always @* begin
        next_read_data = 8'h00;
        case (register_select_lines_i)
            `PDC_RS_WRITE_INDEX: begin
                next_read_data = palette_write_index;
            end
            `PDC_RS_READ_INDEX: begin
                next_read_data = palette_read_index;
            end
            `PDC_RS_INDEXED: begin
                next_read_data = next_indexed_data;
            end
            `PDC_RS_LUT_DATA: begin
                // palette data itself lives outside this block
                next_read_data = 8'h00;
            end
            default: begin
                next_read_data = 8'h00;
            end
        endcase
    end

    pdc_mode_decode u_mode_decode (
        .mode_i(pixel_format_control[`PDC_PF_MODE_HI:`PDC_PF_MODE_LO]),
        .bits_per_pixel_o(dec_bits),
        .clocks_per_group_o(dec_clocks),
        .mode_valid_o(dec_valid)
    );

    pdc_freq_select #(
        .FIRST(1)
    ) u_first_clock (
        .use_reg_i(clock_select_control[`PDC_CS_CLK1_REG]),
        .reg_code_i(clock_select_control[`PDC_CS_CLK1_HI:`PDC_CS_CLK1_LO]),
        .pin_code_i(frequency_select_pins_i),
        .code_o(first_code),
        .freq_khz_o(first_khz)
    );

    pdc_freq_select #(
        .FIRST(0)
    ) u_second_clock (
        .use_reg_i(clock_select_control[`PDC_CS_CLK2_REG]),
        .reg_code_i(clock_select_control[`PDC_CS_CLK2_HI:`PDC_CS_CLK2_LO]),
        .pin_code_i(frequency_select_pins_i),
        .code_o(second_code),
        .freq_khz_o(second_khz)
    );

    // every output is a flop copy; all but read data follow the control state one cycle behind, read data loads on a read strobe

    // read data moves only on a read strobe or a reset, so the host may take it any time before the next read or reset
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            read_data_o <= 8'h00;
        end else if (read_strobe_i) begin
            read_data_o <= next_read_data;
        end
    end

    // color mode decode; reserved codes still pass through, flagged invalid
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            color_mode_o <= 4'h0;
            color_mode_valid_o <= 1'b1;
            bits_per_pixel_o <= 5'h08;
            clocks_per_group_o <= `PDC_CLKS_ONE;
        end else begin
            color_mode_o <= color_mode_field;
            color_mode_valid_o <= dec_valid;
            bits_per_pixel_o <= dec_bits;
            clocks_per_group_o <= dec_clocks;
        end
    end

    // pixel format flags
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            device_power_down_o <= 1'b0;
            eight_bit_data_o <= 1'b0;
            extended_access_o <= 1'b0;
        end else begin
            device_power_down_o <= power_down_field;
            eight_bit_data_o <= eight_bit_field;
            extended_access_o <= ext_access_field;
        end
    end

    // output control flags
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            blank_pedestal_en_o <= 1'b0;
            synth_clock_first_off_o <= 1'b0;
            synth_clock_second_off_o <= 1'b0;
            sense_disable_o <= 1'b0;
        end else begin
            blank_pedestal_en_o <= pedestal_field;
            synth_clock_first_off_o <= first_off_field;
            synth_clock_second_off_o <= second_off_field;
            sense_disable_o <= sense_dis_field;
        end
    end

    // code and rate of one clock share a flop stage, so they agree outside reset, which loads code 0 with a rate of zero
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            first_clock_code_o <= 2'h0;
            first_clock_khz_o <= 17'h00000;
        end else begin
            first_clock_code_o <= first_code;
            first_clock_khz_o <= first_khz;
        end
    end

    // second synthesized clock selection
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            second_clock_code_o <= 2'h0;
            second_clock_khz_o <= 17'h00000;
        end else begin
            second_clock_code_o <= second_code;
            second_clock_khz_o <= second_khz;
        end
    end

    // index registers have no reset, so their copies start from zero here
    // an index never written since power-up reads unknown once reset is released
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            palette_write_index_o <= 8'h00;
            palette_read_index_o <= 8'h00;
        end else begin
            palette_write_index_o <= palette_write_index;
            palette_read_index_o <= palette_read_index;
        end
    end
endmodule

`default_nettype wire

// ===== pdc_regs_checker.sv
`default_nettype none
module pdc_regs_checker (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // host port
    input wire logic [1:0] register_select_lines_i,
    input wire logic read_strobe_i,
    input wire logic [7:0] read_data_o,
    // decoded controls
    input wire logic [3:0] color_mode_o,
    input wire logic color_mode_valid_o,
    input wire logic [4:0] bits_per_pixel_o,
    input wire logic [1:0] clocks_per_group_o,
    input wire logic [1:0] first_clock_code_o,
    input wire logic [16:0] first_clock_khz_o,
    input wire logic [1:0] second_clock_code_o,
    input wire logic [16:0] second_clock_khz_o,
    input wire logic [7:0] palette_write_index_o,
    input wire logic [7:0] palette_read_index_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    logic [3:0] m;
    assign m = color_mode_o;
    rdata_hold_a: assert property (!read_strobe_i |=> $stable(read_data_o)) else $error("read data moved");
    unused_select_a: assert property (read_strobe_i && register_select_lines_i == 2'h1 |=> read_data_o == 8'h00)
        else $error("unused select read not zero");
    reserved_zero_a: assert property (read_strobe_i && register_select_lines_i == 2'h2 |=> (read_data_o &
        (palette_write_index_o == 8'h01 ? 8'h04 : palette_write_index_o == 8'h05 ? 8'hE1 :
        palette_write_index_o == 8'h06 ? 8'h44 : 8'h00)) == 8'h00) else $error("reserved bit set");
    write_index_a: assert property (read_strobe_i && register_select_lines_i == 2'h0 |=>
        read_data_o == palette_write_index_o) else $error("write index mismatch");
    read_index_a: assert property (read_strobe_i && register_select_lines_i == 2'h3 |=>
        read_data_o == palette_read_index_o) else $error("read index mismatch");
    mode_valid_a: assert property (color_mode_valid_o == (m < 4'h8 || m == 4'hE)) else $error("mode valid wrong");
    group_clocks_a: assert property (clocks_per_group_o == (m < 4'h4 || m[3] && m != 4'hE ? 2'h1 :
        m == 4'h7 || m == 4'hE ? 2'h3 : 2'h2)) else $error("clocks per group wrong");
    pixel_bits_a: assert property (m == 4'h7 || m == 4'h5 || m == 4'hE ? bits_per_pixel_o == 5'h18 :
        m == 4'h3 || m == 4'h6 ? bits_per_pixel_o == 5'h10 : m == 4'h1 ? bits_per_pixel_o == 5'h0F :
        bits_per_pixel_o == 5'h08) else $error("pixel bits wrong");
    first_khz_a: assert property ($past(reset_n_i) |-> first_clock_khz_o == (first_clock_code_o == 2'h0 ? 17'h061E1
        : first_clock_code_o == 2'h1 ? 17'h06E1D : first_clock_code_o == 2'h2 ? 17'h0C3C2 : 17'h125A2))
        else $error("first clock rate wrong");
    second_khz_a: assert property ($past(reset_n_i) |-> second_clock_khz_o == (second_clock_code_o == 2'h0 ?
        17'h0751B : second_clock_code_o == 2'h1 ? 17'h09C9B : second_clock_code_o == 2'h2 ? 17'h0C3C2 : 17'h0EA35))
        else $error("second clock rate wrong");
endmodule
bind pdc_regs pdc_regs_checker i_pdc_regs_checker (.ref_clk_i, .reset_n_i, .register_select_lines_i, .read_strobe_i,
    .read_data_o, .color_mode_o, .color_mode_valid_o, .bits_per_pixel_o, .clocks_per_group_o, .first_clock_code_o,
    .first_clock_khz_o, .second_clock_code_o, .second_clock_khz_o, .palette_write_index_o, .palette_read_index_o);
`default_nettype wire

// ===== pdc_host.sv
`default_nettype none
module pdc_host (
    // clock and read data
    input wire logic ref_clk_i,
    input wire logic [7:0] read_data_i,
    // register port
    output logic [1:0] sel_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sel_o = 2'h0;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end
    // released data shows the inverse so stale values never pass
    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        @(negedge ref_clk_i);
        sel_o = s;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge ref_clk_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask
    task automatic rd(input logic [1:0] s, output logic [7:0] d);
        @(negedge ref_clk_i);
        sel_o = s;
        rd_o = 1'b1;
        @(negedge ref_clk_i);
        rd_o = 1'b0;
        d = read_data_i;
    endtask
endmodule
`default_nettype wire

// ===== tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [1:0] fpins = 2'h0;
    logic [1:0] sel, cpg, c1, c2;
    logic wr, rd, cv, dpd, eb, ea, ped, p1, p2, sd;
    logic [7:0] wdata, rdata, g, wix, rix;
    logic [3:0] mode;
    logic [4:0] bpp;
    logic [16:0] k1, k2;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [4:0] bpp_t [16] = '{5'h08, 5'h0F, 5'h08, 5'h10, 5'h08, 5'h18, 5'h10, 5'h18,
        5'h08, 5'h08, 5'h08, 5'h08, 5'h08, 5'h08, 5'h18, 5'h08};
    logic [1:0] cpg_t [16] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3,
        2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h3, 2'h1};
    logic [16:0] f1_t [4] = '{17'h061E1, 17'h06E1D, 17'h0C3C2, 17'h125A2};
    logic [16:0] f2_t [4] = '{17'h0751B, 17'h09C9B, 17'h0C3C2, 17'h0EA35};
    always #2 ref_clk_i = ~ref_clk_i;
    pdc_host i_pdc_host (.ref_clk_i(ref_clk_i), .read_data_i(rdata), .sel_o(sel), .wr_o(wr), .rd_o(rd),
        .wdata_o(wdata));
    pdc_regs i_pdc_regs (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .register_select_lines_i(sel),
        .write_strobe_i(wr), .read_strobe_i(rd), .write_data_i(wdata), .read_data_o(rdata),
        .frequency_select_pins_i(fpins), .color_mode_o(mode), .color_mode_valid_o(cv), .bits_per_pixel_o(bpp),
        .clocks_per_group_o(cpg), .device_power_down_o(dpd), .eight_bit_data_o(eb), .extended_access_o(ea),
        .blank_pedestal_en_o(ped), .synth_clock_first_off_o(p1), .synth_clock_second_off_o(p2),
        .sense_disable_o(sd), .first_clock_code_o(c1), .first_clock_khz_o(k1), .second_clock_code_o(c2),
        .second_clock_khz_o(k2), .palette_write_index_o(wix), .palette_read_index_o(rix));
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic iw(input logic [7:0] idx, input logic [7:0] d);
        i_pdc_host.wr(2'h0, idx);
        i_pdc_host.wr(2'h2, d);
    endtask
    task automatic ir(input logic [7:0] idx, input logic [7:0] exp);
        i_pdc_host.wr(2'h0, idx);
        i_pdc_host.rd(2'h2, g);
        chk(g, exp);
    endtask
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        repeat (6) @(negedge ref_clk_i);
        reset_n_i = 1'b1;
        ir(8'h01, 8'h00);
        ir(8'h05, 8'h00);
        ir(8'h06, 8'h00);
        i_pdc_host.rd(2'h1, g);
        chk(g, 8'h00);
        i_pdc_host.wr(2'h0, 8'h5A);
        i_pdc_host.rd(2'h0, g);
        chk(g, 8'h5A);
        chk(wix, 8'h5A);
        i_pdc_host.wr(2'h3, 8'hA5);
        i_pdc_host.rd(2'h3, g);
        chk(g, 8'hA5);
        chk(rix, 8'hA5);
        $display("reset and index test done");
        for (int m = 0; m < 16; m++) begin
            // the host never programs the reserved color mode codes
            if (m > 7 && m != 14) begin
                continue;
            end
            iw(8'h01, {m[3:0], 4'hF});
            ir(8'h01, {m[3:0], 4'hB});
            chk(mode, m[3:0]);
            chk(bpp, bpp_t[m]);
            chk(cpg, cpg_t[m]);
            chk(cv, m < 8 || m == 14);
            chk({dpd, eb, ea}, 3'h7);
        end
        $display("pixel format test done");
        iw(8'h05, 8'hFF);
        ir(8'h05, 8'h1E);
        chk({ped, p1, p2, sd}, 4'hF);
        iw(8'h05, 8'h00);
        ir(8'h05, 8'h00);
        chk({ped, p1, p2, sd}, 4'h0);
        $display("output control test done");
        for (int c = 0; c < 4; c++) begin
            iw(8'h06, {2'h3, c[1:0], 2'h3, c[1:0]});
            ir(8'h06, {2'h2, c[1:0], 2'h2, c[1:0]});
            chk(k1, f1_t[c]);
            chk(k2, f2_t[c]);
            chk({c1, c2}, {c[1:0], c[1:0]});
        end
        fpins = 2'h2;
        iw(8'h06, 8'h00);
        ir(8'h06, 8'h00);
        chk({c1, c2}, 4'hA);
        chk(k1, f1_t[2]);
        i_pdc_host.wr(2'h1, 8'hFF);
        iw(8'h02, 8'hFF);
        ir(8'h05, 8'h00);
        // the last mode written was 1110, untouched by the stray writes above
        ir(8'h01, 8'hEB);
        $display("clock select test done");
        iw(8'h06, 8'h88);
        i_pdc_host.wr(2'h0, 8'h3C);
        i_pdc_host.wr(2'h3, 8'hC3);
        @(negedge ref_clk_i);
        reset_n_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        reset_n_i = 1'b1;
        i_pdc_host.rd(2'h0, g);
        chk(g, 8'h3C);
        i_pdc_host.rd(2'h3, g);
        chk(g, 8'hC3);
        ir(8'h01, 8'h00);
        ir(8'h06, 8'h00);
        chk({c1, c2}, 4'hA);
        $display("mid-run reset test done");
        finish_test();
    end
endmodule
`default_nettype wire
